/* File: src/spf_status_flags.sv */
// serial status flags: apb slave, dma completion pairing, transfer-end detection
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] receive read while receive buffer empty sets underflow flag, bit 3
// [R2] transmit write while transmit buffer full sets overflow flag, bit 2
// [R3] dma done indication from the channel sets dma-finished flag, bit 1
// [R4] done comes from early close or count exhausted; both mean completion
// [R5] with transmit and receive dma both active, wait for both dones
// [R6] early close: dma-finished and transfer-finished rise in the same cycle
// [R7] description buffers: dma-finished fires for every completed buffer
// [R8] dma-finished has no meaning while dma is disabled
// [R9] manual operation: transfer-finished when count reaches programmed length
// [R10] dma: transfer-finished with dma-finished; buffers: only on the last one
// [R11] halt request plus finished 8-bit unit sets transfer-finished
// [R12] flags reset to zero, stay until a one is written to them; irq status flags clear on a read of irq status instead
// [R13] set and clear in one cycle: the set wins
module spf_status_flags #(
  parameter int LEN_W = spf_pkg::LEN_W_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spf_pkg::spf_evt_s evt,
  output logic irq
);

  localparam int NF = spf_pkg::NFLAG;

  typedef struct packed {
    spf_pkg::spf_ctrl_s ctrl;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] count;
    logic tx_seen;
    logic rx_seen;
    logic [NF-1:0] mask;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } spf_state_s;

  localparam spf_state_s RST_STATE = '{
    ctrl: spf_pkg::CTRL_RST,
    len: spf_pkg::LEN_RST[LEN_W-1:0],
    count: '0,
    tx_seen: 1'b0,
    rx_seen: 1'b0,
    mask: spf_pkg::MASK_RST,
    ack: 1'b0,
    err: 1'b0,
    rdata: 32'h0000_0000
  };

  if (LEN_W < 1 || LEN_W > 32) begin : g_chk
    $error("spf_status_flags: LEN_W out of range");
  end

  spf_state_s s_reg, s_next;

  logic [NF-1:0] stat_flags;
  logic [NF-1:0] irq_flags;
  logic [NF-1:0] ev_set;
  logic [NF-1:0] stat_clr;
  logic [NF-1:0] irq_clr;
  logic access;
  logic done;
  logic both_act;
  logic tx_hit;
  logic rx_hit;
  logic single_done;
  logic dma_fire;
  logic manual;
  logic cnt_hit;
  logic xfer_fire;
  logic halt_fire;
  logic [LEN_W-1:0] cnt_inc;

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state so read data comes from a flop
  assign access = psel & penable;
  assign done = access & s_reg.ack;
  assign pready = done;
  assign pslverr = done & s_reg.err;
  assign prdata = s_reg.rdata;

  // dma completion: a done pulse may come from either close or count end
  always_comb begin
    both_act = s_reg.ctrl.tx_dma & s_reg.ctrl.rx_dma;
    tx_hit = s_reg.tx_seen | evt.dma_tx_done;
    rx_hit = s_reg.rx_seen | evt.dma_rx_done;
    if (s_reg.ctrl.tx_dma) begin
      single_done = evt.dma_tx_done;
    end else if (s_reg.ctrl.rx_dma) begin
      single_done = evt.dma_rx_done;
    end else begin
      single_done = evt.dma_tx_done | evt.dma_rx_done; // see [R4]
    end
    // only meaningful with dma on; held off otherwise
    if (!s_reg.ctrl.dma_en) begin
      dma_fire = 1'b0; // see [R8]
    end else if (both_act) begin
      dma_fire = tx_hit & rx_hit; // see [R5]
    end else begin
      dma_fire = single_done; // see [R3] see [R7]
    end
  end

  // transfer-end sources: manual count, dma, halt request
  always_comb begin
    manual = ~s_reg.ctrl.dma_en & ~s_reg.ctrl.desc_en;
    cnt_inc = LEN_W'(s_reg.count + 1'b1);
    cnt_hit = manual & evt.data_xfer & (cnt_inc == s_reg.len); // see [R9]
    halt_fire = s_reg.ctrl.halt & evt.unit_done; // see [R11]
    // early close also ends a buffered transfer at once
    xfer_fire = cnt_hit | halt_fire
      | (dma_fire & (~s_reg.ctrl.desc_en | evt.desc_last
      | s_reg.ctrl.close_en)); // see [R6] see [R10]
  end

  // event vector shared by status and irq status
  always_comb begin
    ev_set = '0;
    ev_set[spf_pkg::BIT_RXUND] = evt.rx_rd_req & evt.rx_empty; // see [R1]
    ev_set[spf_pkg::BIT_TXOVF] = evt.tx_wr_req & evt.tx_full; // see [R2]
    ev_set[spf_pkg::BIT_DMA] = dma_fire;
    ev_set[spf_pkg::BIT_XFER] = xfer_fire;
  end

  // clears: write one to status; irq status clears what the read returned,
  // so an event that lands between capture and completion is not lost
  always_comb begin
    stat_clr = '0;
    irq_clr = '0;
    if (done && pwrite && paddr == spf_pkg::OFS_STATUS) begin
      stat_clr = pwdata[NF-1:0]; // see [R12]
    end
    if (done && !pwrite && paddr == spf_pkg::OFS_IRQ_STAT) begin
      irq_clr = s_reg.rdata[NF-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state: register decode, writes, dma pairing, length counter
  always_comb begin
    s_next = s_reg;
    s_next.ack = access & ~s_reg.ack;
    if (access && !s_reg.ack) begin
      s_next.err = 1'b0;
      s_next.rdata = 32'h0000_0000;
      case (paddr)
        spf_pkg::OFS_CTRL: begin
          s_next.rdata = 32'(s_reg.ctrl);
        end
        spf_pkg::OFS_LEN: begin
          s_next.rdata = 32'(s_reg.len);
        end
        spf_pkg::OFS_COUNT: begin
          s_next.rdata = 32'(s_reg.count);
        end
        spf_pkg::OFS_STATUS: begin
          s_next.rdata = 32'(stat_flags);
        end
        spf_pkg::OFS_IRQ_STAT: begin
          s_next.rdata = 32'(irq_flags);
        end
        spf_pkg::OFS_IRQ_MASK: begin
          s_next.rdata = 32'(s_reg.mask);
        end
        default: begin
          s_next.err = 1'b1;
        end
      endcase
      if (pwrite) begin
        s_next.rdata = 32'h0000_0000;
      end
    end
    // pairing memory for simultaneous transmit and receive dma
    if (s_reg.ctrl.dma_en && both_act && !dma_fire) begin
      s_next.tx_seen = tx_hit;
      s_next.rx_seen = rx_hit;
    end else begin
      s_next.tx_seen = 1'b0;
      s_next.rx_seen = 1'b0;
    end
    // manual length counter wraps to zero at the programmed length
    if (manual && evt.data_xfer) begin
      s_next.count = cnt_hit ? '0 : cnt_inc;
    end
    // halt is one-shot so it does not refire on later units
    if (halt_fire) begin
      s_next.ctrl.halt = 1'b0;
    end
    if (done && pwrite && !s_reg.err) begin
      case (paddr)
        spf_pkg::OFS_CTRL: begin
          s_next.ctrl = spf_pkg::spf_ctrl_s'(pwdata[spf_pkg::CTRL_W-1:0]);
        end
        spf_pkg::OFS_LEN: begin
          s_next.len = pwdata[LEN_W-1:0];
          s_next.count = '0;
        end
        spf_pkg::OFS_IRQ_MASK: begin
          s_next.mask = pwdata[NF-1:0];
        end
        default: begin
          s_next.mask = s_reg.mask;
        end
      endcase
    end
  end

  // state register; reset brings back the documented idle values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= RST_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag banks
  spf_sticky #(.W(NF)) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(ev_set),
    .clr_i(stat_clr),
    .flags(stat_flags)
  );

  spf_sticky #(.W(NF)) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(ev_set),
    .clr_i(irq_clr),
    .flags(irq_flags)
  );

  // level interrupt while any unmasked irq flag stands
  assign irq = |(irq_flags & s_reg.mask);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RX_UNDERFLOW: assert property (evt.rx_rd_req && evt.rx_empty |=> stat_flags[3]) // see [R1]
    else $error("underflow flag not set");

  AST_RX_NO_FALSE: assert property ($rose(stat_flags[3]) // see [R1]
      |-> $past(evt.rx_rd_req && evt.rx_empty))
    else $error("underflow flag set without cause");

  AST_TX_OVERFLOW: assert property (evt.tx_wr_req && evt.tx_full |=> stat_flags[2]) // see [R2]
    else $error("overflow flag not set");

  AST_DMA_SINGLE: assert property (s_reg.ctrl.dma_en && s_reg.ctrl.tx_dma
      && !s_reg.ctrl.rx_dma && evt.dma_tx_done |=> stat_flags[1]) // see [R3]
    else $error("dma flag missed a done");

  AST_DMA_PAIR: assert property (s_reg.ctrl.dma_en && both_act && !stat_flags[1]
      && evt.dma_tx_done && !evt.dma_rx_done && !s_reg.rx_seen
      ##1 !evt.dma_rx_done && !evt.dma_tx_done && stat_clr == '0
      |=> !stat_flags[1]) // see [R5]
    else $error("dma flag before both channels done");

  AST_DMA_PAIR_END: assert property (s_reg.ctrl.dma_en && both_act
      && s_reg.tx_seen && evt.dma_rx_done |=> stat_flags[1]) // see [R5]
    else $error("dma flag missed second done");

  AST_DMA_OFF: assert property (!s_reg.ctrl.dma_en && !stat_flags[1] && stat_clr == '0
      |=> !stat_flags[1]) // see [R8]
    else $error("dma flag set with dma off");

  AST_SAME_CYCLE: assert property (s_reg.ctrl.dma_en && s_reg.ctrl.close_en && dma_fire
      |=> stat_flags[1] && stat_flags[0]) // see [R6]
    else $error("early close flags not together");

  AST_DESC_EACH: assert property (s_reg.ctrl.dma_en && s_reg.ctrl.desc_en && !both_act
      && single_done |=> stat_flags[1]) // see [R7]
    else $error("buffer done did not set dma flag");

  AST_DESC_NOT_LAST: assert property (s_reg.ctrl.dma_en && s_reg.ctrl.desc_en
      && !s_reg.ctrl.close_en && !evt.desc_last && !stat_flags[0]
      && !cnt_hit && !halt_fire && stat_clr == '0 |=> !stat_flags[0]) // see [R10]
    else $error("transfer flag before last buffer");

  AST_MANUAL_LEN: assert property (manual && evt.data_xfer && cnt_inc == s_reg.len
      |=> stat_flags[0] && s_reg.count == '0) // see [R9]
    else $error("length reached without transfer flag");

  AST_HALT: assert property (s_reg.ctrl.halt && evt.unit_done
      |=> stat_flags[0] && !s_reg.ctrl.halt) // see [R11]
    else $error("halt did not end transfer");

  AST_APB_WAIT: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("apb wait state broken");

  // overflow and dma flags rise only for their own cause; transfer flag follows dma completion
  AST_TX_NO_FALSE: assert property ($rose(stat_flags[2]) // see [R2]
      |-> $past(evt.tx_wr_req && evt.tx_full))
    else $error("overflow flag set without cause");

  AST_DMA_NO_FALSE: assert property ($rose(stat_flags[1]) // see [R8]
      |-> $past(s_reg.ctrl.dma_en))
    else $error("dma flag rose while dma was off");

  AST_XFER_WITH_DMA: assert property (s_reg.ctrl.dma_en && !s_reg.ctrl.desc_en // see [R10]
      && dma_fire |=> stat_flags[1] && stat_flags[0])
    else $error("transfer flag missed dma completion");

  AST_LAST_BUF: assert property (s_reg.ctrl.dma_en && s_reg.ctrl.desc_en // see [R10]
      && dma_fire && evt.desc_last |=> stat_flags[0])
    else $error("transfer flag missed last buffer");

  // write one clears, write zero keeps, unless an event lands at once
  AST_W1C: assert property (done && pwrite && paddr == spf_pkg::OFS_STATUS // see [R12]
      && pwdata[3] && !ev_set[3] |=> !stat_flags[3])
    else $error("write one did not clear the flag");

  AST_W0_KEEP: assert property (done && pwrite && paddr == spf_pkg::OFS_STATUS // see [R12]
      && !pwdata[3] && stat_flags[3] |=> stat_flags[3])
    else $error("write zero cleared a flag");

  // interrupt status read clears what it returned
  AST_IRQ_READ_CLR: assert property (done && !pwrite && paddr == spf_pkg::OFS_IRQ_STAT
      && s_reg.rdata[3] && !ev_set[3] |=> !irq_flags[3])
    else $error("interrupt status read did not clear");

  CVR_PAIR: cover property (s_reg.ctrl.dma_en && both_act && s_reg.tx_seen && evt.dma_rx_done);
  CVR_CLOSE: cover property (s_reg.ctrl.close_en && s_reg.ctrl.desc_en && dma_fire);
  CVR_SET_CLR: cover property ((ev_set & stat_clr) != '0);
  CVR_IRQ: cover property ($rose(irq));
  CVR_HALT: cover property (halt_fire);

endmodule

`default_nettype wire

/* File: src/spf_pkg.sv */
// shared constants and carrier types of the serial status flag block
package spf_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_LEN = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;

  // flag positions, shared by status, irq status and irq mask
  localparam int NFLAG = 4;
  localparam int BIT_XFER = 0;
  localparam int BIT_DMA = 1;
  localparam int BIT_TXOVF = 2;
  localparam int BIT_RXUND = 3;

  // width of the control register and default transfer length width
  localparam int CTRL_W = 6;
  localparam int LEN_W_DEF = 16;

  // control register layout, bit 0 first from the right
  typedef struct packed {
    logic halt;      // bit 5: stop after current 8-bit unit
    logic rx_dma;    // bit 4: receive dma channel in use
    logic tx_dma;    // bit 3: transmit dma channel in use
    logic close_en;  // bit 2: early close of the dma transfer
    logic desc_en;   // bit 1: description buffer operation
    logic dma_en;    // bit 0: dma operation
  } spf_ctrl_s;

  // values after reset
  localparam spf_ctrl_s CTRL_RST = 6'h00;
  localparam logic [31:0] LEN_RST = 32'h0000_0000;
  localparam logic [NFLAG-1:0] MASK_RST = 4'h0;
  localparam logic [NFLAG-1:0] FLAG_RST = 4'h0;

  // events from the shift engine, buffers and the dma channel, all one-cycle pulses
  // except the two buffer levels and the desc_last qualifier
  typedef struct packed {
    logic rx_rd_req;    // firmware read of the receive buffer
    logic rx_empty;     // receive buffer holds no data
    logic tx_wr_req;    // firmware write of the transmit buffer
    logic tx_full;      // transmit buffer full
    logic dma_tx_done;  // dma done, transmit channel
    logic dma_rx_done;  // dma done, receive channel
    logic desc_last;    // qualifies a dma done: last description buffer
    logic data_xfer;    // one data unit moved in manual operation
    logic unit_done;    // current 8-bit unit finished copying
  } spf_evt_s;

endpackage

/* File: src/spf_sticky.sv */
// sticky flag bank: hardware sets, software clears, set has priority
`timescale 1ns/1ns
`default_nettype none

module spf_sticky #(
  parameter int W = spf_pkg::NFLAG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } spf_sticky_state_s;

  spf_sticky_state_s s_reg, s_next;

  if (W < 1 || W > 32) begin : g_chk
    $error("spf_sticky: W out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // set overrides clear so an event in the clearing cycle survives
  always_comb begin
    s_next = s_reg;
    s_next.flags = (s_reg.flags & ~clr_i) | set_i; // see [R13]
  end

  // state register, async reset to all clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.flags <= W'(spf_pkg::FLAG_RST); // see [R12]
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags = s_reg.flags;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SET_WINS: assert property ((set_i & clr_i) != '0 // see [R13]
      |=> ((flags & $past(set_i & clr_i)) == $past(set_i & clr_i)))
    else $error("set lost against clear");
  AST_CLR_ONLY: assert property ((clr_i & ~set_i) != '0 // see [R12]
      |=> (flags & $past(clr_i & ~set_i)) == '0)
    else $error("cleared flag still set");

endmodule

`default_nettype wire

/* File: sim/spf_dma_model.sv */
// dma channel stand-in: counts down its programmed length, then pulses done
`timescale 1ns/1ns
`default_nettype none

module spf_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] chan,
  input wire logic [3:0] cnt,
  input wire logic last,
  output logic tx_done,
  output logic rx_done,
  output logic desc_last
);
  logic busy;
  logic lst;
  logic [1:0] ch;
  logic [3:0] left;

  // done when the count runs out; an early close looks the same at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      lst <= 1'b0;
      ch <= 2'h0;
      left <= 4'h0;
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      desc_last <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      desc_last <= ~lst; // qualifier is garbage outside a done pulse
      if (go) begin
        busy <= 1'b1;
        left <= cnt;
        ch <= chan;
        lst <= last;
      end else if (busy && left == 4'h0) begin
        busy <= 1'b0;
        tx_done <= ch[0];
        rx_done <= ch[1];
        desc_last <= lst;
      end else if (busy) begin
        left <= left - 4'h1;
      end
    end
  end
endmodule

`default_nettype wire

/* File: sim/tb_spf_status_flags.sv */
// self-checking bench of the serial status flag block
`timescale 1ns/1ns
`default_nettype none

module tb_spf_status_flags;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic go, last, txd, rxd, dl;
  logic [1:0] chan;
  logic [3:0] cnt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] ev;
  spf_pkg::spf_evt_s evt;
  logic [32:0] q[$];
  int n_errors, compares;

  ////////////////////////////////////////////////////////////////////////////
  // clock, instances
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always_comb begin
    evt = ev;
    evt.dma_tx_done = txd;
    evt.dma_rx_done = rxd;
    evt.desc_last = dl;
  end
  spf_status_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .irq(irq));
  spf_dma_model dma_i (.pclk(pclk), .presetn(presetn), .go(go), .chan(chan), .cnt(cnt),
    .last(last), .tx_done(txd), .rx_done(rxd), .desc_last(dl));

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; hold is an event word kept up until the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
      input logic [8:0] hold);
    q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    ev <= hold;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= 9'h000;
    @(posedge pclk);
  endtask
  task chk_irq(input logic exp);
    compares++;
    if (irq !== exp) begin
      n_errors++;
      $display("ERROR %0t irq %b expected %b", $time, irq, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e}, 9'h000);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 9'h000);
  endtask
  task pul(input logic [8:0] v);
    ev <= v;
    @(posedge pclk);
    ev <= 9'h000;
    @(posedge pclk);
  endtask
  task dma(input logic [1:0] c, input logic [3:0] n, input logic l);
    go <= 1'b1;
    chan <= c;
    cnt <= n;
    last <= l;
    @(posedge pclk);
    go <= 1'b0;
    repeat (n + 3) @(posedge pclk);
  endtask
  task conclude;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read monitor: every completing edge pops the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, go, last} = 6'h00;
    {paddr, pwdata, ev, chan, cnt} = 59'h0;
    void'($urandom(32'h58e80715));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    pul(9'h100);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    pul(9'h180);
    rd(spf_pkg::OFS_STATUS, 32'h8);
    wr(spf_pkg::OFS_STATUS, 32'h0);
    rd(spf_pkg::OFS_STATUS, 32'h8);
    wr(spf_pkg::OFS_IRQ_MASK, 32'h4);
    pul(9'h060);
    chk_irq(1'b1);
    // both earlier events stand in the interrupt status
    rd(spf_pkg::OFS_IRQ_STAT, 32'hc);
    chk_irq(1'b0);
    apb(1'b1, spf_pkg::OFS_STATUS, 32'hc, 33'h0, 9'h060);
    rd(spf_pkg::OFS_STATUS, 32'h4);
    wr(spf_pkg::OFS_STATUS, 32'h4);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, 12'h0f0, 32'hf, 33'h100000000, 9'h000);
    apb(1'b0, 12'h0f0, 32'h0, 33'h100000000, 9'h000);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    dma(2'h3, 4'h2, 1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    wr(spf_pkg::OFS_CTRL, 32'h19);
    dma(2'h1, 4'h1, 1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    dma(2'h2, 4'h4, 1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_CTRL, 32'h0b);
    dma(2'h1, 4'h0, 1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h2);
    wr(spf_pkg::OFS_STATUS, 32'h2);
    dma(2'h1, 4'h3, 1'b1);
    rd(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_CTRL, 32'h0f);
    dma(2'h1, 4'h2, 1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_STATUS, 32'h3);
    wr(spf_pkg::OFS_CTRL, 32'h0);
    wr(spf_pkg::OFS_LEN, 32'h3);
    pul(9'h002);
    pul(9'h002);
    rd(spf_pkg::OFS_COUNT, 32'h2);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    pul(9'h002);
    rd(spf_pkg::OFS_STATUS, 32'h1);
    wr(spf_pkg::OFS_STATUS, 32'h1);
    wr(spf_pkg::OFS_CTRL, 32'h20);
    pul(9'h001);
    rd(spf_pkg::OFS_STATUS, 32'h1);
    wr(spf_pkg::OFS_STATUS, 32'h1);
    // random buffer levels against both error requests
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      pul({1'b1, r[0], 1'b1, r[1], 5'h00});
      rd(spf_pkg::OFS_STATUS, {28'h0, r[0], r[1], 2'h0});
      wr(spf_pkg::OFS_STATUS, 32'hc);
    end
    // reset in mid-run clears flags, mask and the interrupt
    pul(9'h060);
    chk_irq(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_irq(1'b0);
    rd(spf_pkg::OFS_STATUS, 32'h0);
    rd(spf_pkg::OFS_IRQ_MASK, 32'h0);
    conclude;
  end
endmodule

`default_nettype wire
